// File: design/trx_pkg.sv
// Shared constants and types for the registered nine-bit bus transceiver.
// Assumes a single 100 MHz clock domain and an APB register port.
package trx_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int TRX_W = 9;
  localparam int TRX_DEPTH = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TRX_OFS_CTRL = 8'h00;
  localparam logic [7:0] TRX_OFS_STATUS = 8'h04;
  localparam logic [7:0] TRX_OFS_A_WORD = 8'h08;
  localparam logic [7:0] TRX_OFS_B_WORD = 8'h0C;
  localparam logic [7:0] TRX_OFS_LOG = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TRX_CTRL_GATED = 0;
  localparam int TRX_CTRL_LOG_EN = 1;
  localparam int TRX_ST_A_DRV = 0;
  localparam int TRX_ST_B_DRV = 1;
  localparam int TRX_ST_OFF = 2;
  localparam int TRX_ST_CONT = 3;
  localparam int TRX_ST_OVF = 4;
  localparam int TRX_LOG_SIDE = 9;
  localparam int TRX_LOG_VALID = 31;
  localparam logic [1:0] TRX_CTRL_RST = 2'h2;
  localparam logic [TRX_W-1:0] TRX_DRIVE_RST = 9'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic side;
    logic [TRX_W-1:0] word;
  } trx_log_t;

  typedef enum logic [1:0] {
    TRX_IDLE = 2'b01,
    TRX_ACC = 2'b10
  } trx_apb_st_t;

endpackage

// File: design/trx_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may happen in the same cycle.
`timescale 1ns/10ps
module trx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // --------------------------------------------------------------
  // Handshake decode
  // --------------------------------------------------------------
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rd_ptr_r];

  // Storage, one flop row per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      always_ff @(posedge sys_clk) begin
        if (push && wr_ptr_r == AW'(gi)) begin
          mem_r[gi] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// File: design/trx_side_reg.sv
// One direction of the transceiver: load-clock edge detect plus register.
// Assumes load clock and gate are synchronous levels on sys_clk.
`timescale 1ns/10ps
module trx_side_reg
  import trx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic gated_mode,
  input wire logic load_clock,
  input wire logic clock_gate,
  input wire logic [TRX_W-1:0] src_word,
  output logic load,
  output logic [TRX_W-1:0] drive_r
);
  logic prev_clk_r;
  logic prev_gate_r;
  logic clk_rise;
  logic gate_rise;

  // --------------------------------------------------------------
  // Edge decode
  // --------------------------------------------------------------
  assign clk_rise = load_clock & ~prev_clk_r;
  assign gate_rise = clock_gate & ~prev_gate_r;
  assign load = gated_mode ?
                ((clk_rise & clock_gate) | (gate_rise & load_clock)) :
                clk_rise;

  // Prev levels reset high so a level held through reset is no edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_clk_r <= 1'b1;
      prev_gate_r <= 1'b1;
    end else begin
      prev_clk_r <= load_clock;
      prev_gate_r <= clock_gate;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= TRX_DRIVE_RST;
    end else if (load) begin
      drive_r <= ~src_word;
    end
  end

endmodule

// File: design/trx_bus_xcvr.sv
// Registered nine-bit bidirectional bus transceiver with APB status port.
// Assumes all pin inputs are synchronous to sys_clk; the bench resolves
// each shared bus line from the drive enables.
//
// Notes on behaviour
// - Low drive enable turns that side's nine drivers on; high floats them.
// - Both drive enables high puts both ports in high impedance.
// - Load-clock rising edge captures input word, drives its complement.
// - Gated mode loads on clock edge with gate high, or gate edge with clock high.
// - Registers still load while their outputs are disabled.
// - Driving side's clock may latch its own output for read-back.
// - Outputs float while supply is below the float threshold.
// - Ports and both register paths are nine bits wide.
`timescale 1ns/10ps
module trx_bus_xcvr
  import trx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic a_side_drive_enable_n,
  input wire logic b_side_drive_enable_n,
  input wire logic a_side_load_clock,
  input wire logic b_side_load_clock,
  input wire logic a_side_clock_gate,
  input wire logic b_side_clock_gate,
  input wire logic supply_above_float_threshold,
  input wire logic [TRX_W-1:0] a_bus_lines_seen,
  output logic [TRX_W-1:0] a_bus_lines_drive,
  output logic a_bus_lines_drive_en,
  input wire logic [TRX_W-1:0] b_bus_lines_seen,
  output logic [TRX_W-1:0] b_bus_lines_drive,
  output logic b_bus_lines_drive_en,
  output logic capture_log_ready,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic ovf_r;
  logic a_oe_r;
  logic b_oe_r;
  logic ready_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  trx_apb_st_t st_r;
  trx_apb_st_t st_nxt;
  logic load_to_a;
  logic load_to_b;
  logic gated_mode;
  logic log_en;
  logic setup_ph;
  logic acc_done;
  logic wr_go;
  logic rd_go;
  logic hit_ctrl;
  logic hit_status;
  logic hit_a;
  logic hit_b;
  logic hit_log;
  logic hit_any;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] log_word;
  logic supply_ok;
  logic a_oe_nxt;
  logic b_oe_nxt;
  logic contend;
  logic push_want;
  logic push_lost;
  logic ovf_clr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic log_pop;
  trx_log_t push_data;
  trx_log_t pop_data;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  assign gated_mode = ctrl_r[TRX_CTRL_GATED];
  assign log_en = ctrl_r[TRX_CTRL_LOG_EN];

  // ----------------------------------------------------------------
  // Register paths, one per direction
  // ----------------------------------------------------------------
  // nine-bit path, A lines into the B-facing register
  // Loads no matter what the enables say, which also gives read-back
  // loads ignore enables
  trx_side_reg u_to_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .gated_mode(gated_mode),
    .load_clock(a_side_load_clock),
    .clock_gate(a_side_clock_gate),
    .src_word(a_bus_lines_seen),
    .load(load_to_b),
    .drive_r(b_bus_lines_drive)
  );

  // nine-bit path, B lines into the A-facing register
  trx_side_reg u_to_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .gated_mode(gated_mode),
    .load_clock(b_side_load_clock),
    .clock_gate(b_side_clock_gate),
    .src_word(b_bus_lines_seen),
    .load(load_to_a),
    .drive_r(a_bus_lines_drive)
  );

  // ----------------------------------------------------------------
  // Output control
  // ----------------------------------------------------------------
  // no drive below float threshold
  assign supply_ok = supply_above_float_threshold;
  assign a_oe_nxt = ~a_side_drive_enable_n & supply_ok;
  assign b_oe_nxt = ~b_side_drive_enable_n & supply_ok;
  assign contend = ~a_side_drive_enable_n & ~b_side_drive_enable_n;

  // both high leaves both ports floating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_oe_r <= 1'b0;
      b_oe_r <= 1'b0;
    end else begin
      a_oe_r <= a_oe_nxt;
      b_oe_r <= b_oe_nxt;
    end
  end

  assign a_bus_lines_drive_en = a_oe_r;
  assign b_bus_lines_drive_en = b_oe_r;

  // ----------------------------------------------------------------
  // Capture log
  // ----------------------------------------------------------------
  // Only one push per cycle; a B-side load colliding with an A-side
  // load is dropped and counted as an overflow, a cheap trade for a
  // single-port queue
  assign push_want = log_en & (load_to_b | load_to_a);
  // One driver for the whole entry; side is 0 when taken from A lines
  assign push_data = {~load_to_b,
                      load_to_b ? a_bus_lines_seen : b_bus_lines_seen};
  assign push_lost = (push_want & ~fifo_in_ready) |
                     (log_en & load_to_b & load_to_a);
  assign log_pop = rd_go & hit_log;

  trx_fifo #(
    .WIDTH($bits(trx_log_t)),
    .DEPTH(TRX_DEPTH)
  ) u_log (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_want),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(log_pop),
    .out_data(pop_data)
  );

  // Ready is a registered copy, one cycle behind the queue
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= fifo_in_ready;
    end
  end

  assign capture_log_ready = ready_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready_r;
  assign wr_go = acc_done & pwrite;
  assign rd_go = acc_done & ~pwrite;
  assign hit_ctrl = (paddr == TRX_OFS_CTRL);
  assign hit_status = (paddr == TRX_OFS_STATUS);
  assign hit_a = (paddr == TRX_OFS_A_WORD);
  assign hit_b = (paddr == TRX_OFS_B_WORD);
  assign hit_log = (paddr == TRX_OFS_LOG);
  assign hit_any = hit_ctrl | hit_status | hit_a | hit_b | hit_log;

  // Read words, unused bits zero
  assign status_word = {27'h0, ovf_r, contend,
                        ~a_oe_r & ~b_oe_r, b_oe_r, a_oe_r};
  // Empty queue reads as zero, so a stale entry never leaks out
  assign log_word = fifo_out_valid ? {1'b1, 21'h0, pop_data} : 32'h0;
  assign rd_word = hit_ctrl ? {30'h0, ctrl_r} :
                   hit_status ? status_word :
                   hit_a ? {23'h0, ~a_bus_lines_drive} :
                   hit_b ? {23'h0, ~b_bus_lines_drive} :
                   hit_log ? log_word : 32'h00000000;

  // Two-state slave: answer ready on the first access cycle
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      TRX_IDLE: begin
        if (setup_ph) st_nxt = TRX_ACC;
      end
      TRX_ACC: begin
        st_nxt = TRX_IDLE;
      end
      default: begin
        st_nxt = TRX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TRX_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      pready_r <= (st_r == TRX_IDLE) & setup_ph;
      pslverr_r <= (st_r == TRX_IDLE) & setup_ph & ~hit_any;
      if ((st_r == TRX_IDLE) && setup_ph && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Control and sticky overflow
  // ----------------------------------------------------------------
  assign ovf_clr = wr_go & hit_status & pwdata[TRX_ST_OVF];

  // A new loss in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= TRX_CTRL_RST;
      ovf_r <= 1'b0;
    end else begin
      if (wr_go && hit_ctrl) ctrl_r <= pwdata[1:0];
      ovf_r <= push_lost | (ovf_r & ~ovf_clr);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_float_a: assert property (
    a_side_drive_enable_n |=> !a_bus_lines_drive_en)
    else $error("A side drives while its enable is high");

  a_drive_on_a: assert property (
    !a_side_drive_enable_n && supply_above_float_threshold
    |=> a_bus_lines_drive_en)
    else $error("A side not driving while enabled");

  both_float_a: assert property (
    a_side_drive_enable_n && b_side_drive_enable_n
    |=> !a_bus_lines_drive_en && !b_bus_lines_drive_en
        && status_word[TRX_ST_OFF])
    else $error("Disabled state still drives a port");

  load_invert_a: assert property (
    $rose(b_side_load_clock) && !gated_mode
    |=> a_bus_lines_drive == ~$past(b_bus_lines_seen))
    else $error("A-facing word is not the complement of B input");

  hold_word_a: assert property (
    !load_to_b |=> $stable(b_bus_lines_drive))
    else $error("B-facing word changed without a load");

  gate_hold_a: assert property (
    (gated_mode && !a_side_clock_gate) [*2]
    |=> $stable(b_bus_lines_drive))
    else $error("Gated register loaded while gate low");

  gate_edge_a: assert property (
    gated_mode && a_side_load_clock && $rose(a_side_clock_gate)
    |-> load_to_b)
    else $error("Gate rising with clock high did not load");

  load_off_a: assert property (
    !a_bus_lines_drive_en && !b_bus_lines_drive_en
    && $rose(a_side_load_clock) && !gated_mode
    |=> b_bus_lines_drive == ~$past(a_bus_lines_seen))
    else $error("Load lost while outputs disabled");

  readback_a: assert property (
    a_bus_lines_drive_en && load_to_b
    |=> b_bus_lines_drive == ~$past(a_bus_lines_seen))
    else $error("Read-back latch missed the driven word");

  supply_float_a: assert property (
    !supply_above_float_threshold
    |=> !a_bus_lines_drive_en && !b_bus_lines_drive_en)
    else $error("Port driven below supply threshold");

  contend_flag_a: assert property (
    !a_side_drive_enable_n && !b_side_drive_enable_n
    |-> status_word[TRX_ST_CONT])
    else $error("Both-enabled combination not flagged");

  cover_a_to_b_c: cover property (
    b_bus_lines_drive_en ##0 load_to_b);
  cover_gate_edge_c: cover property (
    gated_mode && $rose(a_side_clock_gate) && a_side_load_clock);
  cover_log_full_c: cover property (!fifo_in_ready ##1 log_pop);
  cover_apb_read_c: cover property (rd_go && hit_log);
  cover_off_load_c: cover property (
    !a_bus_lines_drive_en && !b_bus_lines_drive_en && load_to_a);

endmodule

// File: bench/trx_far_bus.sv
// Far-side party on one nine-bit port of the transceiver.
// Assumes the bench never lets both parties drive the port at once.
`timescale 1ns/10ps
module trx_far_bus
  import trx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic dev_en,
  input wire logic [TRX_W-1:0] dev_word,
  input wire logic far_en,
  input wire logic [TRX_W-1:0] far_word,
  output logic [TRX_W-1:0] seen
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [TRX_W-1:0] float_r = 9'h0AA;
  // No pull on these lines: a floating bus toggles every cycle
  always_ff @(posedge sys_clk) begin
    float_r <= ~seen;
  end
  assign seen = dev_en ? dev_word : (far_en ? far_word : float_r);
endmodule

// File: bench/test_trx_bus_xcvr.sv
// Self-checking bench for the registered nine-bit bus transceiver.
// Assumes the far-side bus model and the APB register map of the package.
`timescale 1ns/10ps
module test_trx_bus_xcvr
  import trx_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk, rst_n, a_oe_n, b_oe_n, a_lclk, b_lclk, a_gate, b_gate;
  logic supply_ok, a_den, b_den, a_fen, b_fen, log_rdy, perr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [TRX_W-1:0] a_seen, a_drv, b_seen, b_drv, a_far, b_far;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [9:0] logq[$];
  logic [TRX_W-1:0] w;
  int miscompares, checks_done;

  trx_bus_xcvr i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .a_side_drive_enable_n(a_oe_n), .b_side_drive_enable_n(b_oe_n),
    .a_side_load_clock(a_lclk), .b_side_load_clock(b_lclk),
    .a_side_clock_gate(a_gate), .b_side_clock_gate(b_gate),
    .supply_above_float_threshold(supply_ok),
    .a_bus_lines_seen(a_seen), .a_bus_lines_drive(a_drv),
    .a_bus_lines_drive_en(a_den), .b_bus_lines_seen(b_seen),
    .b_bus_lines_drive(b_drv), .b_bus_lines_drive_en(b_den),
    .capture_log_ready(log_rdy), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  trx_far_bus i_far_a (.sys_clk(sys_clk), .dev_en(a_den),
    .dev_word(a_drv), .far_en(a_fen), .far_word(a_far), .seen(a_seen));
  trx_far_bus i_far_b (.sys_clk(sys_clk), .dev_en(b_den),
    .dev_word(b_drv), .far_en(b_fen), .far_word(b_far), .seen(b_seen));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic report(input bit bad, input string nm,
      input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (bad) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    report(g !== e, nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic chk_word(input string nm, input logic [TRX_W-1:0] e,
      input logic [TRX_W-1:0] g);
    report(g !== e, nm, 32'(e), 32'(g));
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad,
      input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    tick(1);
    penable <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e,
      input logic ee);
    apb(1'b0, ad, 32'h0);
    report(rdv !== e, "prdata", e, rdv);
    chk_bit("pslverr", ee, perr);
  endtask

  // Far side releases before the device turns round, and vice versa
  task automatic mode(input logic an, input logic bn);
    a_fen <= 1'b0;
    b_fen <= 1'b0;
    a_oe_n <= an;
    b_oe_n <= bn;
    tick(2);
    a_fen <= an;
    b_fen <= bn;
    tick(1);
  endtask

  // One rising edge of a load clock, low again before the next one
  task automatic pulse(input bit b_side);
    if (b_side) begin
      b_lclk <= 1'b1;
    end else begin
      a_lclk <= 1'b1;
    end
    tick(1);
    a_lclk <= 1'b0;
    b_lclk <= 1'b0;
    tick(2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    a_oe_n = 1'b1;
    b_oe_n = 1'b1;
    a_lclk = 1'b0;
    b_lclk = 1'b0;
    a_gate = 1'b0;
    b_gate = 1'b0;
    supply_ok = 1'b1;
    a_fen = 1'b0;
    b_fen = 1'b0;
    a_far = 9'h000;
    b_far = 9'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    checks_done = 0;
    tick(5);
    chk_bit("a_den", 1'b0, a_den);
    rst_n <= 1'b1;
    tick(1);
    rd_chk(TRX_OFS_CTRL, 32'(TRX_CTRL_RST), 1'b0);
    rd_chk(TRX_OFS_STATUS, 32'h4, 1'b0);
    // B drives, A listens: A loads go out on B inverted
    mode(1'b1, 1'b0);
    chk_bit("a_den", 1'b0, a_den);
    chk_bit("b_den", 1'b1, b_den);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 9'h1A5 : (i == 1) ? 9'h000 :
          (i == 2) ? 9'h1FF : 9'h0F0;
      a_far <= w;
      pulse(1'b0);
      chk_word("b_drv", ~w, b_drv);
      chk_word("b_seen", ~w, b_seen);
      rd_chk(TRX_OFS_B_WORD, 32'(w), 1'b0);
      logq.push_back({1'b0, w});
    end
    // Read-back: driving side latches its own output
    pulse(1'b1);
    chk_word("a_drv", w, a_drv);
    logq.push_back({1'b1, ~w});
    // Disabled state still loads
    mode(1'b1, 1'b1);
    b_far <= 9'h155;
    pulse(1'b1);
    chk_word("a_drv", ~9'h155, a_drv);
    logq.push_back({1'b1, 9'h155});
    mode(1'b0, 1'b1);
    chk_word("a_seen", ~9'h155, a_seen);
    supply_ok <= 1'b0;
    tick(2);
    chk_bit("a_den", 1'b0, a_den);
    supply_ok <= 1'b1;
    tick(2);
    chk_bit("a_den", 1'b1, a_den);
    // Gated loads: gate low blocks, gate edge loads
    apb(1'b1, TRX_OFS_CTRL, 32'h3);
    b_far <= 9'h0C3;
    pulse(1'b1);
    chk_word("a_drv", ~9'h155, a_drv);
    b_lclk <= 1'b1;
    tick(2);
    b_gate <= 1'b1;
    tick(1);
    b_lclk <= 1'b0;
    b_gate <= 1'b0;
    tick(2);
    chk_word("a_drv", ~9'h0C3, a_drv);
    b_far <= 9'h13C;
    b_gate <= 1'b1;
    tick(1);
    pulse(1'b1);
    b_gate <= 1'b0;
    chk_word("a_drv", ~9'h13C, a_drv);
    logq.push_back({1'b1, 9'h0C3});
    logq.push_back({1'b1, 9'h13C});
    apb(1'b1, TRX_OFS_CTRL, 32'h2);
    // Log now full: next capture is lost and flagged
    chk_bit("log_rdy", 1'b0, log_rdy);
    b_far <= 9'h0AA;
    pulse(1'b1);
    rd_chk(TRX_OFS_STATUS, 32'h11, 1'b0);
    apb(1'b1, TRX_OFS_STATUS, 32'h10);
    rd_chk(TRX_OFS_STATUS, 32'h1, 1'b0);
    foreach (logq[i]) begin
      rd_chk(TRX_OFS_LOG, {1'b1, 21'h0, logq[i]}, 1'b0);
    end
    rd_chk(TRX_OFS_LOG, 32'h0, 1'b0);
    chk_bit("log_rdy", 1'b1, log_rdy);
    // Read-only and unmapped places
    apb(1'b1, TRX_OFS_A_WORD, 32'h0);
    rd_chk(TRX_OFS_A_WORD, 32'h0AA, 1'b0);
    rd_chk(8'h20, 32'h0, 1'b1);
    mode(1'b0, 1'b0);
    rd_chk(TRX_OFS_STATUS, 32'hB, 1'b0);
    finish_test();
  end
endmodule
